// *** logic/pbl_pkg.sv ***
// Purpose : constants shared by the pll band/loop configuration block
// Assumes : 16-bit serial frames, one instruction byte then one data byte
// Notes   : register map and field layout of the pll control registers
package pbl_pkg;

   // ***************************************************************
   // register map
   // ***************************************************************
   localparam logic [4:0] ADDR_BAND = 5'h08;     // band select register
   localparam logic [4:0] ADDR_BIAS = 5'h09;     // enable and bias register
   localparam logic [4:0] ADDR_BWV  = 5'h0A;     // loop bandwidth and vctl

   // ***************************************************************
   // field layout and reset values
   // ***************************************************************
   localparam int         BAND_LSB  = 2;         // band field bits 7:2
   localparam int         PLLEN_BIT = 7;         // pll enable bit
   localparam int         VCTL_LSB  = 5;         // control voltage bits 7:5
   localparam logic [5:0] BAND_AUTO = 6'h3F;     // all-ones code starts search
   localparam logic [5:0] BAND_LAST = 6'h3E;     // highest fixed band
   localparam logic [5:0] BAND_RST  = 6'h00;     // band code after reset
   localparam logic [4:0] BW_RST    = 5'h0F;     // loop bandwidth after reset
   localparam logic [7:0] BIAS_RST  = 8'h03;     // bias reg after reset
   localparam logic [2:0] VCTL_LO   = 3'h2;      // lowest acceptable vctl
   localparam logic [2:0] VCTL_HI   = 3'h4;      // highest acceptable vctl

   // ***************************************************************
   // serial frame
   // ***************************************************************
   localparam logic [4:0] FRAME_LAST = 5'h0F;    // index of last frame bit
   localparam logic [4:0] INSTR_LAST = 5'h07;    // index of last instruction bit
   localparam logic [4:0] DATA_FIRST = 5'h08;    // index of first data bit

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int CLK_MHZ    = 10;               // system clock rate
   localparam int SETTLE_NS  = 10000;            // least settling time per band
   localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;

   // search sequencer states, gray along the path
   typedef enum logic [1:0] {
      PBL_IDLE   = 2'b00,
      PBL_SETTLE = 2'b01,
      PBL_CHECK  = 2'b11,
      PBL_DONE   = 2'b10
   } pbl_state_t;

endpackage

// *** logic/pbl_pll_cfg.sv ***
// Purpose : pll band select, loop bandwidth, bias and vctl registers
// Assumes : serial port pins synchronous to CLK, slower than CLK / 4
// Notes   : band search steps bands upward until vctl sits mid-range or the top fixed band is reached
module pbl_pll_cfg
   import pbl_pkg::*;
#(
   parameter int SETTLE_CYCLES = SETTLE_CYC      // settle wait per band
) (
   input  wire logic       CLK,
   input  wire logic       NRST,
   input  wire logic       SCLK,
   input  wire logic       CS_N,
   input  wire logic       SDI,
   output logic            SDO,
   output logic            SDO_OE,
   input  wire logic [2:0] VCTL,
   output logic            PLL_EN,
   output logic [5:0]      BAND,
   output logic [4:0]      LOOP_BW,
   output logic [2:0]      BIAS,
   output logic            SEARCH_BUSY
);

   // ***************************************************************
   // reset release
   // ***************************************************************
   logic             rst_meta_r;                 // first release stage
   logic             rst_n_r;                    // released reset copy

   // two stages so release never lands near an edge
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   // ***************************************************************
   // serial port
   // ***************************************************************
   logic             sclk_prev_r;                // sclk one cycle ago
   logic [4:0]       bit_cnt_r;                  // bits taken this frame
   logic [14:0]      shift_in_r;                 // incoming bits
   logic [7:0]       shift_out_r;                // outgoing read data
   logic             is_read_r;                  // frame is a read
   logic             sclk_rise;                  // rising sclk in frame
   logic             sclk_fall;                  // falling sclk in frame
   logic [15:0]      frame_nxt;                  // frame with current bit
   logic             wr_stb;                     // full write frame taken
   logic [4:0]       wr_addr;                    // write address
   logic [7:0]       wr_data;                    // write data
   logic [7:0]       rd_data;                    // read mux

   assign sclk_rise = SCLK & ~sclk_prev_r & ~CS_N;
   assign sclk_fall = ~SCLK & sclk_prev_r & ~CS_N;
   assign frame_nxt = {shift_in_r, SDI};
   assign wr_addr   = frame_nxt[12:8];
   assign wr_data   = frame_nxt[7:0];
   assign wr_stb    = sclk_rise & (bit_cnt_r == FRAME_LAST) & ~frame_nxt[15];

   // edge history of the serial clock
   always_ff @(posedge CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sclk_prev_r <= 1'b0;
      end else begin
         sclk_prev_r <= SCLK;
      end
   end

   // bit capture; deasserted select aborts a partial frame
   always_ff @(posedge CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         bit_cnt_r  <= 5'h00;
         shift_in_r <= 15'h0000;
      end else if (CS_N) begin
         bit_cnt_r  <= 5'h00;
      end else if (sclk_rise) begin
         shift_in_r <= frame_nxt[14:0];
         bit_cnt_r  <= bit_cnt_r + 5'h01;
      end
   end

   // read data loaded after the instruction, shifted out on falls
   always_ff @(posedge CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         shift_out_r <= 8'h00;
         is_read_r   <= 1'b0;
         SDO         <= 1'b0;
         SDO_OE      <= 1'b0;
      end else begin
         if (CS_N) begin
            is_read_r <= 1'b0;
         end else if (sclk_rise && bit_cnt_r == INSTR_LAST) begin
            is_read_r   <= frame_nxt[7];
            shift_out_r <= rd_data;
         end else if (sclk_fall && bit_cnt_r >= DATA_FIRST) begin
            SDO         <= shift_out_r[7];
            shift_out_r <= {shift_out_r[6:0], 1'b0};
         end
         // drive only during the data phase of a read
         SDO_OE <= ~CS_N & is_read_r & (bit_cnt_r >= DATA_FIRST);
      end
   end

   // ***************************************************************
   // configuration registers
   // ***************************************************************
   logic [5:0]       band_code_r;                // last written band code
   logic [1:0]       band_low_r;                 // spare bits 1:0 of band reg
   logic [7:0]       bias_reg_r;                 // enable, spare, bias
   logic [4:0]       bw_r;                       // loop bandwidth code
   logic [2:0]       vctl_r;                     // sampled control voltage
   logic [5:0]       found_r;                    // band under test or found
   logic             auto_mode;                  // search code is written

   assign auto_mode = (band_code_r == BAND_AUTO);

   // host writes; a manual code is kept as written
   always_ff @(posedge CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         band_code_r <= BAND_RST;
         band_low_r  <= 2'b00;
         bias_reg_r  <= BIAS_RST;
         bw_r        <= BW_RST;
      end else if (wr_stb) begin
         case (wr_addr)
            ADDR_BAND: begin
               band_code_r <= wr_data[7:BAND_LSB];
               band_low_r  <= wr_data[1:0];
            end
            ADDR_BIAS: bias_reg_r <= wr_data;
            ADDR_BWV:  bw_r <= wr_data[4:0];
            default:   ;                          // unmapped writes ignored
         endcase
      end
   end

   // vctl field is read-only, sampled from the filter comparator
   always_ff @(posedge CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         vctl_r <= 3'h0;
      end else begin
         vctl_r <= VCTL;
      end
   end

   // readback mux; unmapped addresses read zero
   always_comb begin
      rd_data = 8'h00;
      case (frame_nxt[4:0])
         ADDR_BAND: rd_data = {(auto_mode ? found_r : band_code_r), band_low_r};
         ADDR_BIAS: rd_data = bias_reg_r;
         ADDR_BWV:  rd_data = {vctl_r, bw_r};
         default:   rd_data = 8'h00;
      endcase
   end

   // ***************************************************************
   // band search
   // ***************************************************************
   pbl_state_t       state_r;                    // sequencer state
   logic [15:0]      settle_cnt_r;               // wait per band
   logic             vctl_ok;                    // vctl inside window

   assign vctl_ok = (vctl_r >= VCTL_LO) && (vctl_r <= VCTL_HI);

   // steps bands upward; ends at the first centred band or the top
   always_ff @(posedge CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r      <= PBL_IDLE;
         settle_cnt_r <= 16'h0000;
         found_r      <= 6'h00;
      end else if (wr_stb && wr_addr == ADDR_BAND) begin
         settle_cnt_r <= 16'h0000;
         found_r      <= 6'h00;
         // search code restarts, any manual code stops it
         state_r <= (wr_data[7:BAND_LSB] == BAND_AUTO) ? PBL_SETTLE : PBL_IDLE;
      end else begin
         case (state_r)
            PBL_SETTLE: begin
               settle_cnt_r <= settle_cnt_r + 16'h0001;
               if (settle_cnt_r >= 16'(SETTLE_CYCLES - 1)) begin
                  state_r <= PBL_CHECK;
               end
            end
            PBL_CHECK: begin
               settle_cnt_r <= 16'h0000;
               if (vctl_ok || found_r == BAND_LAST) begin
                  state_r <= PBL_DONE;
               end else begin
                  found_r <= found_r + 6'h01;
                  state_r <= PBL_SETTLE;
               end
            end
            PBL_DONE: state_r <= PBL_DONE;        // result held for readback
            PBL_IDLE: state_r <= PBL_IDLE;
            default:  state_r <= PBL_IDLE;
         endcase
      end
   end

   // ***************************************************************
   // analog control outputs
   // ***************************************************************
   // registered so every pin comes from a flop
   always_ff @(posedge CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         BAND        <= BAND_RST;
         LOOP_BW     <= BW_RST;
         BIAS        <= BIAS_RST[2:0];
         PLL_EN      <= BIAS_RST[PLLEN_BIT];
         SEARCH_BUSY <= 1'b0;
      end else begin
         BAND        <= auto_mode ? found_r : band_code_r;
         LOOP_BW     <= bw_r;
         BIAS        <= bias_reg_r[2:0];
         PLL_EN      <= bias_reg_r[PLLEN_BIT];
         SEARCH_BUSY <= (state_r == PBL_SETTLE) || (state_r == PBL_CHECK);
      end
   end

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!rst_n_r);

   sequence s_band_wr;
      wr_stb && wr_addr == ADDR_BAND;
   endsequence

   sequence s_settle_two;
      (state_r == PBL_SETTLE) [*2];
   endsequence

   search_start_a: assert property (s_band_wr ##0 wr_data[7:BAND_LSB] == BAND_AUTO
      |=> s_settle_two) else $error("search did not start");

   manual_hold_a: assert property (s_band_wr ##0 wr_data[7:BAND_LSB] != BAND_AUTO
      |-> ##2 (BAND == $past(wr_data[7:BAND_LSB], 2)))
      else $error("manual band not kept");

   search_done_a: assert property ((state_r == PBL_CHECK) && vctl_ok && !wr_stb
      |=> (state_r == PBL_DONE) && $stable(found_r) ##1 BAND == found_r)
      else $error("search result lost");

   loop_bw_a: assert property (wr_stb && wr_addr == ADDR_BWV
      |-> ##2 LOOP_BW == $past(wr_data[4:0], 2)) else $error("bandwidth not applied");

   vctl_read_a: assert property (sclk_rise && bit_cnt_r == INSTR_LAST
      && frame_nxt[4:0] == ADDR_BWV |=> shift_out_r[7:VCTL_LSB] == $past(vctl_r))
      else $error("vctl readback wrong");

   pll_enable_a: assert property (wr_stb && wr_addr == ADDR_BIAS
      |-> ##2 PLL_EN == $past(wr_data[PLLEN_BIT], 2)) else $error("enable not applied");

endmodule

// *** bench/pbl_host_model.sv ***
// Purpose : host side of the serial configuration port
// Assumes : each serial clock phase lasts 4 CLK cycles
// Notes   : drives just after a CLK edge, samples read data before each rise
module pbl_host_model
   import pbl_pkg::*;
(
   input  wire logic CLK,
   output logic      SCLK,
   output logic      CS_N,
   output logic      SDI,
   input  wire logic SDO
);
   timeunit 1ns;
   timeprecision 100ps;

   // ************************************************************
   // idle state, port deselected
   // ************************************************************
   initial begin
      SCLK = 1'b0;
      CS_N = 1'b1;
      SDI  = 1'b0;
   end

   // wait n edges, then step just past the edge
   task automatic wt(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask

   // one 16-bit frame, msb first; read data is taken before each rise
   task automatic xfer(input logic rd, input logic [4:0] adr, input logic [7:0] wd,
                       output logic [7:0] rdat);
      logic [15:0] fr;
      fr   = {rd, 2'b00, adr, wd};
      rdat = 8'h00;
      CS_N = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         SDI = fr[i];
         wt(4);
         if (i < 8) rdat[i] = SDO;
         SCLK = 1'b1;
         wt(4);
         SCLK = 1'b0;
      end
      wt(4);
      CS_N = 1'b1;
      // released line must not keep showing the last bit
      SDI = ~SDI;
      wt(4);
   endtask

   // start-up programming with a stored band value
   task automatic startup_cfg(input logic [5:0] bnd);
      logic [7:0] d;
      xfer(1'b0, ADDR_BWV, 8'h0F, d);
      xfer(1'b0, ADDR_BIAS, 8'h83, d);
      xfer(1'b0, ADDR_BAND, {bnd, 2'b00}, d);
   endtask
endmodule

// *** bench/pll_band_loop_config_tb.sv ***
// Purpose : self-checking bench of the pll band/loop configuration block
// Assumes : short settle count so a full band scan stays brief
// Notes   : the analog loop is modelled as vctl rising once band passes a threshold
module pll_band_loop_config_tb
   import pbl_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int SETTLE_T = 4;  // shortened per-band settle wait
   localparam int OE_SPAN  = 71; // read drive: 8 data bits of 8 cycles, tail to select high
   int         oe_cnt;           // cycles seen with read drive enabled
   logic       clk, nrst, sclk, cs_n, sdi, sdo, sdo_oe, pll_en, search_busy;
   logic [2:0] vctl, bias, vctl_fix;
   logic [5:0] band, model_thr;
   logic [4:0] loop_bw;
   logic       search_mode;
   int         bad_count, cmp_count;

   always #50 clk = ~clk;
   // crude loop model: vctl lands mid-range once band reaches the threshold
   assign vctl = search_mode ? ((band >= model_thr) ? 3'h3 : 3'h1) : vctl_fix;

   pbl_pll_cfg #(.SETTLE_CYCLES(SETTLE_T)) pbl_pll_cfg_i (
      .CLK(clk), .NRST(nrst), .SCLK(sclk), .CS_N(cs_n), .SDI(sdi), .SDO(sdo),
      .SDO_OE(sdo_oe), .VCTL(vctl), .PLL_EN(pll_en), .BAND(band),
      .LOOP_BW(loop_bw), .BIAS(bias), .SEARCH_BUSY(search_busy));
   pbl_host_model pbl_host_model_i (
      .CLK(clk), .SCLK(sclk), .CS_N(cs_n), .SDI(sdi), .SDO(sdo));

   // count cycles with read drive on; an unknown never counts, so it shows as short
   always @(posedge clk) begin
      if (sdo_oe === 1'b1) oe_cnt++;
   end

   // ************************************************************
   // shared helpers
   // ************************************************************
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // read drive must cover the data phase and drop once select is high
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      int c0;
      c0 = oe_cnt;
      pbl_host_model_i.xfer(1'b1, a, 8'h00, d);
      chk("oe span", 8'(oe_cnt - c0), 8'(OE_SPAN));
      chk("oe idle", {7'b0, sdo_oe}, 8'h00);
   endtask
   // a write frame never turns the read drive on
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      logic [7:0] d;
      int         c0;
      c0 = oe_cnt;
      pbl_host_model_i.xfer(1'b0, a, v, d);
      chk("oe on write", 8'(oe_cnt - c0), 8'h00);
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_reset();
      logic [7:0] d;
      chk("band out", {2'b00, band}, 8'h00);
      chk("bw out", {3'b000, loop_bw}, {3'b000, BW_RST});
      chk("pll en", {7'b0, pll_en}, 8'h00);
      rd(ADDR_BAND, d);
      chk("band reg", d, 8'h00);
      rd(ADDR_BIAS, d);
      chk("bias reg", d, BIAS_RST);
      $display("test reset done");
   endtask

   // fixed codes incl. top fixed band and a step to the adjacent band
   task automatic t_manual();
      logic [7:0] codes[4] = '{8'h00, 8'hFB, 8'h14, 8'h18};
      logic [7:0] d;
      foreach (codes[k]) begin
         wr(ADDR_BAND, codes[k]);
         rd(ADDR_BAND, d);
         chk("band reg", d, codes[k]);
         chk("band out", {2'b00, band}, {2'b00, codes[k][7:2]});
      end
      $display("test manual done");
   endtask

   task automatic t_bw();
      logic [4:0] bws[3] = '{5'h00, 5'h1F, 5'h0F};
      logic [7:0] d;
      foreach (bws[k]) begin
         vctl_fix = 3'(k * 3 + 2);
         wr(ADDR_BWV, {3'b111, bws[k]});
         rd(ADDR_BWV, d);
         chk("bw reg", d, {vctl_fix, bws[k]});
         chk("bw out", {3'b000, loop_bw}, {3'b000, bws[k]});
      end
      wr(ADDR_BIAS, 8'h83);
      chk("pll on", {4'h0, pll_en, bias}, 8'h0B);
      wr(ADDR_BIAS, 8'h05);
      chk("pll off", {4'h0, pll_en, bias}, 8'h05);
      $display("test bandwidth done");
   endtask

   task automatic t_search(input logic [5:0] thr, input logic [5:0] exp);
      logic [7:0] d;
      int         n;
      search_mode = 1'b1;
      model_thr   = thr;
      wr(ADDR_BAND, 8'hFC);
      chk("busy", {7'b0, search_busy}, 8'h01);
      n = 0;
      while (search_busy !== 1'b0 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      #1;
      rd(ADDR_BAND, d);
      chk("found band", d, {exp, 2'b00});
      pbl_host_model_i.startup_cfg(d[7:2]);
      chk("band kept", {search_busy, 1'b0, band}, {2'b00, exp});
      rd(ADDR_BWV, d);
      chk("vctl ok", {7'b0, d[7:5] >= VCTL_LO && d[7:5] <= VCTL_HI},
          {7'b0, exp >= thr});
      search_mode = 1'b0;
      $display("test search done");
   endtask

   task automatic t_unmapped();
      logic [7:0] d;
      wr(5'h1F, 8'hAA);
      rd(5'h1F, d);
      chk("unmapped", d, 8'h00);
      rd(ADDR_BAND, d);
      chk("band intact", d, {BAND_LAST, 2'b00});
      $display("test unmapped done");
   endtask

   // ************************************************************
   // run control
   // ************************************************************
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      clk         = 1'b0;
      nrst        = 1'b0;
      search_mode = 1'b0;
      model_thr   = 6'h00;
      vctl_fix    = 3'h0;
      bad_count   = 0;
      cmp_count   = 0;
      repeat (2) @(posedge clk);
      #1 nrst = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      t_reset();
      t_manual();
      t_bw();
      t_search(6'd20, 6'd20);
      t_search(6'd63, BAND_LAST);
      t_unmapped();
      tally_and_finish();
   end

   // watchdog: about five times the expected run
   initial begin
      repeat (25000) @(posedge clk);
      bad_count++;
      tally_and_finish();
   end
endmodule
